// file: scpr_pkg.sv
// constants and types for the calibration pattern readout block
package scpr_pkg;
  localparam int          ADDR_W       = 14;
  localparam int          DQ_W         = 16;
  localparam int          LAT_W        = 5;
  localparam logic [2:0]  BA_MODE_THREE = 3'h3;
  localparam int          MODE_BIT     = 2;
  localparam logic [1:0]  LOC_PREDEF   = 2'h0;
  localparam int          CHOP_BIT     = 12;
  localparam int          NIBBLE_BIT   = 2;
  localparam int          AP_BIT       = 10;
  localparam logic [7:0]  PREDEF_PATTERN = 8'haa;
  localparam logic [3:0]  BEATS_FULL   = 4'h8;
  localparam logic [3:0]  BEATS_CHOP   = 4'h4;
  localparam logic [2:0]  NIBBLE_HIGH  = 3'h4;
  localparam logic [2:0]  NIBBLE_LOW   = 3'h0;

  typedef enum logic [2:0] {
    SCPR_CMD_NOP   = 3'h0,
    SCPR_CMD_MRS   = 3'h1,
    SCPR_CMD_READ  = 3'h2,
    SCPR_CMD_WRITE = 3'h3,
    SCPR_CMD_OTHER = 3'h4
  } scpr_cmd_t;

  typedef struct packed {
    scpr_cmd_t          cmd;
    logic [2:0]         bank;
    logic [ADDR_W-1:0]  addr;
  } scpr_req_t;

  typedef enum logic [1:0] {
    SCPR_IDLE  = 2'h0,
    SCPR_WAIT  = 2'h1,
    SCPR_BURST = 2'h2
  } scpr_state_t;
endpackage

// file: scpr_readout.sv
// mode register three and calibration pattern read path
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: mode register three written by mode-set with bank bits 011.
// R2: address bit 2 enables pattern mode; zero keeps array operation.
// R3: location 00 selects predefined pattern; other values are reserved.
// R4: location field ignored while pattern mode is off.
// R5: controller drives address bits 3 to 13 low on this write.
// R6: controller precharges all banks before enabling pattern mode; the bench issues no precharge first.
// R7: in pattern mode every read comes from the pattern register.
// R8: controller issues only reads while pattern mode is on.
// R9: reset is honoured while pattern mode is enabled.
// R10: read with autoprecharge acts as a plain read in pattern mode.
// R11: with pattern mode off reads and writes use the array.
// R12: eight-beat read gives order 0 to 7, pattern 0101 0101.
// R13: chopped read gives order 0-3 or 4-7 by address bit 2.
// R14: burst bit 0 is pattern lsb, bit 7 its msb.
// R15: bit 0 of each byte lane carries pattern, others copy or zero.
// R16: controller drives column bits 1:0 low, bit 2 low for eight beats.
// R17: bank bits and other column bits are ignored in pattern reads.
// R18: address bit 12 chops on the fly when enabled; fixed chop honoured.
// R19: pattern reads keep the ordinary read latency and timing.
// R20: controller reads the pattern only after delay-lock; the bench reads it with no delay-lock step.
// R21: read latency equals additive plus column access latency.
// R22: after reset pattern mode is off.
module scpr_readout
  import scpr_pkg::*;
#(
  parameter bit COPY_LANES = 1'b1
)(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire scpr_req_t        req,
  input  wire logic [LAT_W-1:0] additive_latency,
  input  wire logic [LAT_W-1:0] cas_latency,
  input  wire logic             chop_on_fly_en,
  input  wire logic             chop_fixed,
  input  wire logic [DQ_W-1:0]  array_rd_data,
  output logic                  pattern_mode,
  output logic [1:0]            pattern_location,
  output logic                  array_rd_req,
  output logic                  array_wr_req,
  output logic                  array_autoprecharge,
  output logic [DQ_W-1:0]       dq_out,
  output logic                  dq_oe
);

  // refuse widths the lane fan-out and latency counter cannot serve
  if ((DQ_W % 8 != 0) || (DQ_W < 16))
  begin : g_bad_width
    $error("data width must be two or more whole byte lanes");
  end
  if (LAT_W < 1)
  begin : g_bad_latency
    $error("latency width must be at least one bit");
  end

  // fans one pattern bit out over every byte lane
  function automatic logic [DQ_W-1:0] lane_fill(input logic b);
    logic [DQ_W-1:0] v;
    v = '0;
    for (int i = 0; i < DQ_W; i++)
      if (COPY_LANES || (i % 8 == 0))
        v[i] = b;
    return v;
  endfunction

  logic              is_mrs3;
  logic              is_read;
  logic              is_write;
  logic [LAT_W:0]    read_lat;
  logic [LAT_W:0]    lat_cnt;
  logic [3:0]        beat_cnt;
  logic [3:0]        beats;
  logic [2:0]        burst_pos;
  logic              burst_src;
  scpr_state_t       state;

  // R1 mode-set decode
  assign is_mrs3 = (req.cmd == SCPR_CMD_MRS) && (req.bank == BA_MODE_THREE);
  assign is_read = (req.cmd == SCPR_CMD_READ);
  assign is_write = (req.cmd == SCPR_CMD_WRITE);
  // R21 latency sum
  assign read_lat = {1'b0, additive_latency} + {1'b0, cas_latency};

  // R2 mode register write
  always_ff @(posedge sys_clk)
  begin
    // R9 reset during pattern mode
    if (rst)
    begin
      // R22 off after reset
      pattern_mode     <= 1'b0;
      pattern_location <= LOC_PREDEF;
    end
    else if (is_mrs3)
    begin
      pattern_mode     <= req.addr[MODE_BIT];
      pattern_location <= req.addr[1:0];
    end
  end

  // R11 array access when mode off
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      array_rd_req        <= 1'b0;
      array_wr_req        <= 1'b0;
      array_autoprecharge <= 1'b0;
    end
    else
    begin
      // R7 reads diverted in pattern mode
      array_rd_req        <= is_read && !pattern_mode;
      array_wr_req        <= is_write && !pattern_mode;
      // R10 no autoprecharge in pattern mode
      array_autoprecharge <= (is_read || is_write)
                             && !pattern_mode && req.addr[AP_BIT];
    end
  end

  // R19 shared latency and burst sequencing
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state     <= SCPR_IDLE;
      lat_cnt   <= '0;
      beat_cnt  <= '0;
      beats     <= BEATS_FULL;
      burst_pos <= NIBBLE_LOW;
      burst_src <= 1'b0;
    end
    else
    begin
      case (state)
        SCPR_IDLE:
        begin
          if (is_read)
          begin
            // R17 only chop and nibble bits matter
            // R18 chop on the fly or fixed
            if (chop_on_fly_en)
              beats <= req.addr[CHOP_BIT] ? BEATS_FULL : BEATS_CHOP;
            else
              beats <= chop_fixed ? BEATS_CHOP : BEATS_FULL;
            // R13 nibble select
            burst_pos <= req.addr[NIBBLE_BIT] ? NIBBLE_HIGH : NIBBLE_LOW;
            // R4 location not consulted
            burst_src <= pattern_mode;
            lat_cnt   <= read_lat;
            beat_cnt  <= '0;
            state     <= (read_lat == '0) ? SCPR_BURST : SCPR_WAIT;
          end
        end
        SCPR_WAIT:
        begin
          lat_cnt <= lat_cnt - 1'b1;
          if (lat_cnt == {{LAT_W{1'b0}}, 1'b1})
            state <= SCPR_BURST;
        end
        SCPR_BURST:
        begin
          // R12 ascending burst order
          burst_pos <= burst_pos + 3'h1;
          beat_cnt  <= beat_cnt + 4'h1;
          if (beat_cnt == beats - 4'h1)
            state <= SCPR_IDLE;
        end
        default:
          state <= SCPR_IDLE;
      endcase
    end
  end

  logic pat_bit;
  // R14 burst bit indexes pattern lsb first
  // R3 reserved locations give the same pattern
  assign pat_bit = PREDEF_PATTERN[burst_pos];

  // R15 data pins drive
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end
    else if (state == SCPR_BURST)
    begin
      dq_out <= burst_src ? lane_fill(pat_bit) : array_rd_data;
      dq_oe  <= 1'b1;
    end
    else
    begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end
  end

  // read latencies probed by the checks below
  localparam logic [LAT_W:0] LAT_TWO   = (LAT_W+1)'(2);
  localparam logic [LAT_W:0] LAT_THREE = (LAT_W+1)'(3);

  // R1 mode register captured
  mode_write_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    is_mrs3 |=> pattern_mode == $past(req.addr[MODE_BIT]))
    else $error("mode bit not captured");

  // R1 location field captured
  loc_write_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    is_mrs3 |=> pattern_location == $past(req.addr[1:0]))
    else $error("location not captured");

  // R1 other mode registers ignored
  mrs_other_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    (req.cmd == SCPR_CMD_MRS && req.bank != BA_MODE_THREE) |=> $stable(pattern_mode))
    else $error("mode changed by other register");

  // R4 location kept without write
  loc_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
    !is_mrs3 |=> $stable(pattern_location))
    else $error("location changed without write");

  // R7 no array read in pattern mode
  no_array_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
    (is_read && pattern_mode) |=> !array_rd_req)
    else $error("array read in pattern mode");

  // R10 no precharge in pattern mode
  no_ap_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
    pattern_mode |=> !array_autoprecharge)
    else $error("autoprecharge in pattern mode");

  // R11 normal reads go to array
  array_read_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
    (is_read && !pattern_mode) |=> array_rd_req)
    else $error("array read missing");

  // R11 normal writes go to array
  array_write_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
    (is_write && !pattern_mode) |=> array_wr_req)
    else $error("array write missing");

  // R12 alternating pattern on every beat
  pattern_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
    (dq_oe && burst_src) |-> (dq_out[0] == PREDEF_PATTERN[$past(burst_pos)]))
    else $error("pattern bit wrong");

  // R15 upper lane mirrors lower
  lanes_a: assert property (@(posedge sys_clk) disable iff (rst) // R15
    (dq_oe && burst_src) |-> (dq_out[8] == dq_out[0]))
    else $error("upper lane bit 0 differs");

  // R15 lane bits above zero copy or stay low
  lane_copy_a: assert property (@(posedge sys_clk) disable iff (rst) // R15
    (dq_oe && burst_src)
    |-> (dq_out[7:1] == (COPY_LANES ? {7{dq_out[0]}} : 7'h0)))
    else $error("lane bits 7 to 1 wrong");

  // R22 reset leaves pattern off
  reset_off_a: assert property (@(posedge sys_clk) // R22
    rst |=> !pattern_mode)
    else $error("pattern mode after reset");

  // R9 reset clears dq_oe, both array requests and the location
  reset_quiet_a: assert property (@(posedge sys_clk) // R9
    rst |=> (!dq_oe && !array_rd_req && !array_wr_req && pattern_location == LOC_PREDEF))
    else $error("outputs active after reset");

  // R19 data begins after latency of two
  latency_a: assert property (@(posedge sys_clk) disable iff (rst) // R19
    (state == SCPR_IDLE && is_read && read_lat == LAT_TWO)
    |=> !dq_oe[*3] ##1 dq_oe)
    else $error("read latency wrong");

  // R21 data begins after latency of three
  latency_three_a: assert property (@(posedge sys_clk) disable iff (rst) // R21
    (state == SCPR_IDLE && is_read && read_lat == LAT_THREE)
    |=> !dq_oe[*4] ##1 dq_oe)
    else $error("read latency of three wrong");

  // R18 full burst without chop
  full_len_a: assert property (@(posedge sys_clk) disable iff (rst) // R18
    ($rose(dq_oe) && !chop_on_fly_en && !chop_fixed) |-> dq_oe[*8] ##1 !dq_oe)
    else $error("full burst length wrong");

  // R18 fixed chop gives four beats
  chop_len_a: assert property (@(posedge sys_clk) disable iff (rst) // R18
    ($rose(dq_oe) && !chop_on_fly_en && chop_fixed) |-> dq_oe[*4] ##1 !dq_oe)
    else $error("chopped burst length wrong");

  enable_c: cover property (@(posedge sys_clk) is_mrs3 && req.addr[MODE_BIT]);
  chop_c: cover property (@(posedge sys_clk) state == SCPR_IDLE && is_read && pattern_mode
    && chop_on_fly_en && !req.addr[CHOP_BIT] && req.addr[NIBBLE_BIT]);
  full_c: cover property (@(posedge sys_clk) burst_src && state == SCPR_BURST
    && beat_cnt == 4'h7);
  disable_c: cover property (@(posedge sys_clk) pattern_mode && is_mrs3
    && !req.addr[MODE_BIT]);
  pattern_read_c: cover property (@(posedge sys_clk) state == SCPR_IDLE && is_read
    && pattern_mode && req.addr[AP_BIT]);

endmodule
`default_nettype wire

// file: scpr_ctrl_model.sv
// controller model driving commands into the readout block
`timescale 1ns/100ps
`default_nettype none
module scpr_ctrl_model
  import scpr_pkg::*;
(
  input  wire logic      sys_clk,
  output var  scpr_req_t req
);
  initial req = '{SCPR_CMD_NOP, 3'h0, 14'h0};
  task automatic issue(input scpr_cmd_t c, input logic [2:0] b, input logic [13:0] a);
    @(posedge sys_clk);
    #1 req = '{c, b, a};
    @(posedge sys_clk);
    // released lines show the inverse of the last value
    #1 req = '{SCPR_CMD_NOP, ~b, ~a};
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the calibration pattern readout
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import scpr_pkg::*;
  logic             sys_clk;
  logic             rst;
  logic             chop_on_fly_en;
  logic             chop_fixed;
  logic [LAT_W-1:0] additive_latency;
  logic [LAT_W-1:0] cas_latency;
  logic [DQ_W-1:0]  array_rd_data;
  logic [DQ_W-1:0]  dq_out;
  logic [1:0]       pattern_location;
  logic             pattern_mode;
  logic             array_rd_req;
  logic             array_wr_req;
  logic             array_autoprecharge;
  logic             dq_oe;
  scpr_req_t        req;
  int               miscompares = 0;
  int               check_count = 0;

  scpr_ctrl_model ctrl (.sys_clk(sys_clk), .req(req));
  scpr_readout dut (.sys_clk(sys_clk), .rst(rst), .req(req),
    .additive_latency(additive_latency), .cas_latency(cas_latency),
    .chop_on_fly_en(chop_on_fly_en), .chop_fixed(chop_fixed),
    .array_rd_data(array_rd_data), .pattern_mode(pattern_mode),
    .pattern_location(pattern_location), .array_rd_req(array_rd_req),
    .array_wr_req(array_wr_req), .array_autoprecharge(array_autoprecharge),
    .dq_out(dq_out), .dq_oe(dq_oe));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one read; pat picks pattern or array data as the expected source
  task automatic burst(input logic [13:0] a, input int beats, input int start, input bit pat);
    int n;
    n = 0;
    ctrl.issue(SCPR_CMD_READ, 3'h5, a);
    chk({15'h0, array_rd_req}, {15'h0, !pat});
    chk({15'h0, array_autoprecharge}, {15'h0, !pat && a[10]});
    while (dq_oe !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 40)
    begin
      miscompares++;
      finish_test();
    end
    chk(16'(n), 16'(additive_latency + cas_latency + 1));
    for (int k = 0; k < beats; k++)
    begin
      chk(dq_out, pat ? {16{PREDEF_PATTERN[start + k]}} : array_rd_data);
      @(posedge sys_clk);
      #1;
    end
    chk({15'h0, dq_oe}, 16'h0);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial
  begin
    rst = 1'b1;
    chop_on_fly_en = 1'b0;
    chop_fixed = 1'b0;
    additive_latency = 5'h0;
    cas_latency = 5'h2;
    array_rd_data = 16'h5a3c;
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk({15'h0, pattern_mode}, 16'h0);
    ctrl.issue(SCPR_CMD_MRS, BA_MODE_THREE, 14'h3);
    chk({14'h0, pattern_location}, 16'h3);
    chk({15'h0, pattern_mode}, 16'h0);
    burst(14'h0400, 8, 0, 1'b0);
    ctrl.issue(SCPR_CMD_WRITE, 3'h0, 14'h0);
    chk({15'h0, array_wr_req}, 16'h1);
    ctrl.issue(SCPR_CMD_MRS, 3'h2, 14'h4);
    chk({15'h0, pattern_mode}, 16'h0);
    ctrl.issue(SCPR_CMD_MRS, BA_MODE_THREE, 14'h4);
    chk({13'h0, pattern_location, pattern_mode}, 16'h1);
    additive_latency = 5'h1;
    burst(14'h1400, 8, 0, 1'b1);
    chop_on_fly_en = 1'b1;
    burst(14'h0004, 4, 4, 1'b1);
    burst(14'h2ff8, 4, 0, 1'b1);
    burst(14'h1000, 8, 0, 1'b1);
    chop_on_fly_en = 1'b0;
    chop_fixed = 1'b1;
    burst(14'h0004, 4, 4, 1'b1);
    ctrl.issue(SCPR_CMD_MRS, BA_MODE_THREE, 14'h5);
    burst(14'h0000, 4, 0, 1'b1);
    ctrl.issue(SCPR_CMD_MRS, BA_MODE_THREE, 14'h0);
    chk({15'h0, pattern_mode}, 16'h0);
    ctrl.issue(SCPR_CMD_MRS, BA_MODE_THREE, 14'h4);
    chk({15'h0, pattern_mode}, 16'h1);
    rst = 1'b1;
    @(posedge sys_clk);
    #1 rst = 1'b0;
    chk({15'h0, pattern_mode}, 16'h0);
    finish_test();
  end
endmodule
`default_nettype wire
